// ---- logic/matrix_map_config_commands.sv ----
// matrix map and configuration command block: remap tables, routing state,
// level configuration and version, driven by commands and register writes over apb
// assumes pclk at 250 MHz, apb master per the amba rules, one clock domain
//
// Behaviour
// - full destination list walks logical numbers, reporting only remapped ones, per level
// - destination get reports per-level physical mapping of one logical destination
// - destination set without level remaps that destination on every level
// - destination set with level remaps only that level, others untouched
// - full source list walks logical numbers, reporting only remapped ones, per level
// - source get reports per-level physical mapping of one logical source
// - source set without level remaps that source on every level
// - source set with level remaps only that level
// - map commands accepted only when protocol version is 3.0 or later
// - version query returns major, minor and whether minor is shown
// - configuration selector is sum of names 1, routing state 2, presets 4
// - no-argument configuration gives only the level count; per level destination count, source count, flags are in the level config registers
// - level flags: mute 1, lock query 2, reclocker disable 4
// - configuration argument 0 to 7 gives the descriptive response
// - descriptive response carries matrix status ok, updating, remote lost, error
// - level names hold at most eight characters
// - level type is video, audio, hd, vga, 3g, analog or aes
// - descriptive response carries no flags; mute, lock, reclk bits are read from the level config registers
// - source values start at 1, 0 is mute, -1 no change for presets
`include "mm_consts.svh"
`timescale 1ns/1ns
`default_nettype none

module matrix_map_config_commands
   import mm_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr
);

   function automatic logic in_range(input logic [4:0] v, input logic [4:0] c);
      return (v != 5'h00) && (v <= c);
   endfunction : in_range

   // level 0 means every level, so the numbers must fit each one
   function automatic logic map_ok(input logic [4:0] a, input logic [4:0] b,
                                   input logic [1:0] lvl, input logic [1:0][4:0] cnt);
      logic ok;
      ok = 1'b0;
      case (lvl)
         2'h0:    ok = in_range(a, cnt[0]) && in_range(b, cnt[0]) && in_range(a, cnt[1]) && in_range(b, cnt[1]);
         2'h1:    ok = in_range(a, cnt[0]) && in_range(b, cnt[0]);
         2'h2:    ok = in_range(a, cnt[1]) && in_range(b, cnt[1]);
         default: ok = 1'b0;
      endcase
      return ok;
   endfunction : map_ok

   function automatic logic [3:0] slot(input logic [4:0] n);
      return 4'(n - 5'h01);
   endfunction : slot

   function automatic logic [31:0] entry(input logic [4:0] n, input table_t t);
      logic [31:0] r;
      r = 32'h0000_0000;
      r[`MM_RES_VALID] = 1'b1;
      r[`MM_RES_LOG_LSB +: 5] = n;
      r[`MM_RES_P1_LSB +: 5] = t[1][slot(n)];
      r[`MM_RES_P0_LSB +: 5] = t[0][slot(n)];
      return r;
   endfunction : entry

   function automatic logic remapped(input logic [4:0] n, input table_t t);
      return (t[0][slot(n)] != n) || (t[1][slot(n)] != n);
   endfunction : remapped

   // routing state values are 1-based with 0 as mute; -1 only ever leaves for preset data
   function automatic logic [7:0] src_code(input logic [4:0] v, input logic no_change);
      return no_change ? 8'hFF : {3'h0, v};
   endfunction : src_code

   state_t s;
   state_t s_next;

   logic       access;
   logic       wr_edge;
   logic       cmd_fire;
   op_t        op;
   logic       has_arg;
   logic [4:0] arg_a;
   logic [4:0] arg_b;
   logic [1:0] arg_lvl;
   logic       map_gate;

   assign access   = psel && penable;
   assign wr_edge  = access && s.ack && pwrite;
   assign cmd_fire = wr_edge && (paddr == `MM_OFF_CMD) && !s.busy;
   assign op       = op_t'(pwdata[`MM_CMD_OP_LSB +: 4]);
   assign has_arg  = pwdata[`MM_CMD_ARG_BIT];
   assign arg_a    = pwdata[`MM_CMD_A_LSB +: 5];
   assign arg_b    = pwdata[`MM_CMD_B_LSB +: 5];
   assign arg_lvl  = pwdata[`MM_CMD_LVL_LSB +: 2];
   assign map_gate = (`MM_VER_MAJOR >= `MM_VER_MAP_MIN);

   assign prdata  = s.prdata;
   assign pready  = access && s.ack;
   assign pslverr = access && s.ack && s.slverr;

   always_comb begin
      s_next = s;
      s_next.ack = access && !s.ack;

      // first access cycle: decode and latch the answer, pready follows one cycle later
      if (access && !s.ack) begin
         s_next.slverr = 1'b0;
         s_next.prdata = 32'h0000_0000;
         if (paddr == `MM_OFF_CMD) begin
            s_next.slverr = pwrite && s.busy;
         end else if (paddr == `MM_OFF_STATUS) begin
            s_next.prdata[`MM_ST_BUSY] = s.busy;
            s_next.prdata[`MM_ST_DONE] = s.done;
            s_next.prdata[`MM_ST_ERR] = s.err;
            s_next.prdata[`MM_ST_MSTAT_LSB +: 2] = s.mstat;
         end else if (paddr == `MM_OFF_RESULT) begin
            s_next.prdata = s.result;
         end else if (paddr == `MM_OFF_VERSION) begin
            s_next.prdata = {15'h0000, `MM_VER_HAS_MIN, `MM_VER_MAJOR, `MM_VER_MINOR};
         end else if (paddr == `MM_OFF_CTRL) begin
            s_next.prdata[1:0] = s.mstat;
         end else begin
            s_next.slverr = 1'b1;
            for (int l = 0; l < `MM_LEVELS; l++) begin
               if (paddr == 8'(`MM_OFF_LCFG0 + 8'(l) * `MM_LCFG_STRIDE)) begin
                  s_next.slverr = 1'b0;
                  s_next.prdata[4:0] = s.dcnt[l];
                  s_next.prdata[`MM_LCFG_SCNT_LSB +: 5] = s.scnt[l];
                  s_next.prdata[`MM_LCFG_FLAG_LSB +: 3] = s.lflags[l];
                  s_next.prdata[`MM_LCFG_TYPE_LSB +: 3] = s.ltype[l];
               end
               if (paddr == 8'(`MM_OFF_LNAME0 + 8'(l) * `MM_LNAME_STRIDE)) begin
                  s_next.slverr = 1'b0;
                  s_next.prdata = s.lname[l][31:0];
               end
               if (paddr == 8'(`MM_OFF_LNAME0 + 8'(l) * `MM_LNAME_STRIDE + 8'h04)) begin
                  s_next.slverr = 1'b0;
                  s_next.prdata = s.lname[l][63:32];
               end
            end
         end
      end

      // register writes land only at the edge that sees pready high
      if (wr_edge && !s.slverr) begin
         if (paddr == `MM_OFF_CTRL) begin
            s_next.mstat = mtx_status_t'(pwdata[1:0]);
         end
         for (int l = 0; l < `MM_LEVELS; l++) begin
            if (paddr == 8'(`MM_OFF_LCFG0 + 8'(l) * `MM_LCFG_STRIDE)) begin
               if (pwdata[4:0] <= `MM_MAX_IO) s_next.dcnt[l] = pwdata[4:0];
               if (pwdata[`MM_LCFG_SCNT_LSB +: 5] <= `MM_MAX_IO) s_next.scnt[l] = pwdata[`MM_LCFG_SCNT_LSB +: 5];
               s_next.lflags[l] = pwdata[`MM_LCFG_FLAG_LSB +: 3];
               // unknown type codes are dropped so the keyword stays one of the seven
               if (pwdata[`MM_LCFG_TYPE_LSB +: 3] != 3'h7) begin
                  s_next.ltype[l] = level_type_t'(pwdata[`MM_LCFG_TYPE_LSB +: 3]);
               end
            end
            // two words per level: a name can never exceed eight bytes
            if (paddr == 8'(`MM_OFF_LNAME0 + 8'(l) * `MM_LNAME_STRIDE)) begin
               s_next.lname[l][31:0] = pwdata;
            end
            if (paddr == 8'(`MM_OFF_LNAME0 + 8'(l) * `MM_LNAME_STRIDE + 8'h04)) begin
               s_next.lname[l][63:32] = pwdata;
            end
         end
      end

      case (s.fsm)
         S_IDLE: begin
            if (cmd_fire) begin
               s_next.done = 1'b1;
               s_next.err = 1'b0;
               s_next.result = 32'h0000_0000;
               case (op)
                  OP_DMAP_SET, OP_SMAP_SET: begin
                     if (!map_gate || !map_ok(arg_a, arg_b, arg_lvl, (op == OP_DMAP_SET) ? s.dcnt : s.scnt)) begin
                        s_next.err = 1'b1;
                     end else begin
                        for (int l = 0; l < `MM_LEVELS; l++) begin
                           if ((arg_lvl == 2'h0) || (arg_lvl == 2'(l + 1))) begin
                              if (op == OP_DMAP_SET) s_next.dmap[l][slot(arg_a)] = arg_b;
                              else s_next.smap[l][slot(arg_a)] = arg_b;
                           end
                        end
                     end
                  end
                  OP_DMAP_GET, OP_SMAP_GET: begin
                     if (!map_gate || !map_ok(arg_a, arg_a, 2'h0, (op == OP_DMAP_GET) ? s.dcnt : s.scnt)) begin
                        s_next.err = 1'b1;
                     end else if (op == OP_DMAP_GET) begin
                        s_next.result = entry(arg_a, s.dmap);
                     end else begin
                        s_next.result = entry(arg_a, s.smap);
                     end
                  end
                  OP_DMAP_NEXT, OP_SMAP_NEXT: begin
                     if (!map_gate) begin
                        s_next.err = 1'b1;
                     end else begin
                        // the walk takes one cycle per logical number, so busy guards the tables
                        s_next.fsm = S_SCAN;
                        s_next.busy = 1'b1;
                        s_next.done = 1'b0;
                        s_next.scan_src = (op == OP_SMAP_NEXT);
                        s_next.idx = arg_a;
                     end
                  end
                  OP_VERSION: begin
                     s_next.result = {1'b1, 14'h0000, `MM_VER_HAS_MIN, `MM_VER_MAJOR, `MM_VER_MINOR};
                  end
                  OP_CFG_QUERY: begin
                     s_next.result[`MM_RES_VALID] = 1'b1;
                     if (!has_arg) begin
                        s_next.result[1:0] = 2'(`MM_LEVELS);
                     end else if (arg_a <= `MM_MAX_SEL) begin
                        s_next.result[`MM_RES_DESCR] = 1'b1;
                        s_next.result[`MM_RES_SEL_LSB +: 3] = arg_a[2:0];
                        s_next.result[`MM_RES_ST_LSB +: 2] = s.mstat;
                        s_next.result[1:0] = 2'(`MM_LEVELS);
                     end else begin
                        s_next.result = 32'h0000_0000;
                        s_next.err = 1'b1;
                     end
                  end
                  OP_ROUTE_SET: begin
                     // source 0 is accepted as mute on any level
                     if (arg_lvl == 2'h0 || arg_lvl == 2'h3 || !in_range(arg_a, s.dcnt[arg_lvl[1]])
                         || (arg_b > s.scnt[arg_lvl[1]])) begin
                        s_next.err = 1'b1;
                     end else begin
                        s_next.route[arg_lvl[1]][slot(arg_a)] = arg_b;
                     end
                  end
                  OP_ROUTE_GET: begin
                     if (arg_lvl == 2'h0 || arg_lvl == 2'h3 || !in_range(arg_a, s.dcnt[arg_lvl[1]])) begin
                        s_next.err = 1'b1;
                     end else begin
                        s_next.result = {1'b1, 23'h00_0000, src_code(s.route[arg_lvl[1]][slot(arg_a)], 1'b0)};
                     end
                  end
                  default: begin
                     s_next.err = 1'b1;
                  end
               endcase
            end
         end
         S_SCAN: begin
            if ((s.idx == 5'h00) || (s.idx > `MM_MAX_IO)) begin
               s_next.fsm = S_IDLE;
               s_next.busy = 1'b0;
               s_next.done = 1'b1;
               s_next.result = 32'h0000_0000;
               s_next.result[`MM_RES_END] = 1'b1;
            end else if (remapped(s.idx, s.scan_src ? s.smap : s.dmap)) begin
               s_next.fsm = S_IDLE;
               s_next.busy = 1'b0;
               s_next.done = 1'b1;
               s_next.result = entry(s.idx, s.scan_src ? s.smap : s.dmap);
            end else begin
               s_next.idx = 5'(s.idx + 5'h01);
            end
         end
         default: begin
            s_next.fsm = S_IDLE;
            s_next.busy = 1'b0;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s.fsm <= S_IDLE;
         for (int l = 0; l < `MM_LEVELS; l++) begin
            for (int i = 0; i < 16; i++) begin
               s.dmap[l][i] <= 5'(i + 1);
               s.smap[l][i] <= 5'(i + 1);
               s.route[l][i] <= 5'(i + 1);
            end
            s.dcnt[l] <= `MM_RST_DCNT;
            s.scnt[l] <= `MM_RST_SCNT;
            s.lflags[l] <= `MM_RST_FLAGS;
            s.ltype[l] <= LT_VIDEO;
            s.lname[l] <= 64'h0000_0000_0000_0000;
         end
         s.mstat <= MS_OK;
         s.result <= 32'h0000_0000;
         s.busy <= 1'b0;
         s.done <= 1'b0;
         s.err <= 1'b0;
         s.scan_src <= 1'b0;
         s.idx <= 5'h00;
         s.ack <= 1'b0;
         s.prdata <= 32'h0000_0000;
         s.slverr <= 1'b0;
      end else begin
         s <= s_next;
      end
   end

   a_scan_ends: assert property (@(posedge pclk) disable iff (!presetn)
      $rose(s.busy) |-> ##[1:17] (!s.busy && s.done))
      else $error("map walk did not finish in time");

   a_next_remapped: assert property (@(posedge pclk) disable iff (!presetn)
      (s.fsm == S_SCAN) ##1 (s.fsm == S_IDLE && s.result[`MM_RES_VALID])
      |-> remapped(s.result[`MM_RES_LOG_LSB +: 5], $past(s.scan_src) ? s.smap : s.dmap))
      else $error("map walk reported an entry that is not remapped");

   a_dset_all: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_fire && op == OP_DMAP_SET && arg_lvl == 2'h0 && map_ok(arg_a, arg_b, 2'h0, s.dcnt))
      |=> (s.dmap[0][slot($past(arg_a))] == $past(arg_b)) && (s.dmap[1][slot($past(arg_a))] == $past(arg_b)))
      else $error("destination set missed a level");

   a_dset_one: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_fire && op == OP_DMAP_SET && arg_lvl == 2'h1) |=> $stable(s.dmap[1]))
      else $error("single level destination set touched another level");

   a_sset_one: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_fire && op == OP_SMAP_SET && arg_lvl == 2'h2 && map_ok(arg_a, arg_b, 2'h2, s.scnt))
      |=> $stable(s.smap[0]) && (s.smap[1][slot($past(arg_a))] == $past(arg_b)))
      else $error("single level source set wrong");

   a_reject_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_fire && (op == OP_DMAP_SET || op == OP_SMAP_SET)
       && !map_ok(arg_a, arg_b, arg_lvl, (op == OP_DMAP_SET) ? s.dcnt : s.scnt))
      |=> s.err && $stable(s.dmap) && $stable(s.smap))
      else $error("rejected assignment changed a table");

   a_get_result: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_fire && op == OP_DMAP_GET && map_ok(arg_a, arg_a, 2'h0, s.dcnt))
      |=> s.result[`MM_RES_VALID] && (s.result[`MM_RES_P0_LSB +: 5] == s.dmap[0][slot($past(arg_a))])
          && (s.result[`MM_RES_P1_LSB +: 5] == s.dmap[1][slot($past(arg_a))]))
      else $error("destination get result mismatch");

   a_cfg_range: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_fire && op == OP_CFG_QUERY && has_arg)
      |=> (s.result[`MM_RES_DESCR] == ($past(arg_a) <= `MM_MAX_SEL)) && (s.err == ($past(arg_a) > `MM_MAX_SEL)))
      else $error("configuration argument range handled wrongly");

   a_ver_result: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_fire && op == OP_VERSION) |=> (s.result[15:8] == `MM_VER_MAJOR) && s.done && !s.err)
      else $error("version query result wrong");

   a_cfg_plain: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_fire && op == OP_CFG_QUERY && !has_arg)
      |=> s.result[`MM_RES_VALID] && !s.result[`MM_RES_DESCR] && (s.result[1:0] == 2'(`MM_LEVELS)))
      else $error("compact configuration result wrong");

   a_route_get: assert property (@(posedge pclk) disable iff (!presetn)
      (cmd_fire && op == OP_ROUTE_GET && arg_lvl == 2'h1 && in_range(arg_a, s.dcnt[0]))
      |=> s.result[`MM_RES_VALID] && (s.result[7:0] == {3'h0, s.route[0][slot($past(arg_a))]}))
      else $error("route get result wrong");

   a_type_keep: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_edge && !s.slverr && paddr == `MM_OFF_LCFG0 && pwdata[`MM_LCFG_TYPE_LSB +: 3] == 3'h7)
      |=> $stable(s.ltype[0]))
      else $error("reserved level type code was stored");

endmodule : matrix_map_config_commands

`default_nettype wire

// ---- logic/mm_consts.svh ----
// constants for the matrix map and configuration command block
// assumes inclusion by logic that sits behind an apb slave port
`ifndef MM_CONSTS_SVH
`define MM_CONSTS_SVH

// register byte offsets
`define MM_OFF_CMD      8'h00
`define MM_OFF_STATUS   8'h04
`define MM_OFF_RESULT   8'h08
`define MM_OFF_VERSION  8'h0C
`define MM_OFF_CTRL     8'h10
`define MM_OFF_LCFG0    8'h14
`define MM_OFF_LNAME0   8'h20
`define MM_LCFG_STRIDE  8'h04
`define MM_LNAME_STRIDE 8'h08

// command word fields
`define MM_CMD_OP_LSB   0
`define MM_CMD_ARG_BIT  4
`define MM_CMD_A_LSB    8
`define MM_CMD_B_LSB    16
`define MM_CMD_LVL_LSB  24

// result word fields
`define MM_RES_VALID    31
`define MM_RES_END      30
`define MM_RES_DESCR    29
`define MM_RES_LOG_LSB  24
`define MM_RES_P1_LSB   8
`define MM_RES_P0_LSB   0
`define MM_RES_SEL_LSB  16
`define MM_RES_ST_LSB   8

// level config fields
`define MM_LCFG_SCNT_LSB  8
`define MM_LCFG_FLAG_LSB  16
`define MM_LCFG_TYPE_LSB  20

// status fields
`define MM_ST_BUSY      0
`define MM_ST_DONE      1
`define MM_ST_ERR       2
`define MM_ST_MSTAT_LSB 4

// sizes and reset values
`define MM_LEVELS       2
`define MM_MAX_IO       5'h10
`define MM_RST_DCNT     5'h08
`define MM_RST_SCNT     5'h08
`define MM_RST_FLAGS    3'h3
`define MM_MAX_SEL      5'h07

// level feature flag bits
`define MM_FLAG_MUTE    0
`define MM_FLAG_LOCK    1
`define MM_FLAG_RECLK   2

// protocol version reported and the least version that carries map commands
`define MM_VER_MAJOR    8'h03
`define MM_VER_MINOR    8'h00
`define MM_VER_HAS_MIN  1'b1
`define MM_VER_MAP_MIN  8'h03

`endif

// ---- logic/mm_pkg.sv ----
// types for the matrix map and configuration command block
// assumes mm_consts.svh is compiled alongside
package mm_pkg;

   typedef enum logic [3:0] {
      OP_NONE      = 4'b0000,
      OP_DMAP_SET  = 4'b0001,
      OP_DMAP_GET  = 4'b0010,
      OP_DMAP_NEXT = 4'b0011,
      OP_SMAP_SET  = 4'b0100,
      OP_SMAP_GET  = 4'b0101,
      OP_SMAP_NEXT = 4'b0110,
      OP_VERSION   = 4'b0111,
      OP_CFG_QUERY = 4'b1000,
      OP_ROUTE_SET = 4'b1001,
      OP_ROUTE_GET = 4'b1010
   } op_t;

   typedef enum logic [0:0] {
      S_IDLE = 1'b0,
      S_SCAN = 1'b1
   } fsm_t;

   typedef enum logic [2:0] {
      LT_VIDEO  = 3'b000,
      LT_AUDIO  = 3'b001,
      LT_HD     = 3'b010,
      LT_VGA    = 3'b011,
      LT_3G     = 3'b100,
      LT_ANALOG = 3'b101,
      LT_AES    = 3'b110
   } level_type_t;

   typedef enum logic [1:0] {
      MS_OK          = 2'b00,
      MS_UPDATING    = 2'b01,
      MS_REMOTE_LOST = 2'b10,
      MS_ERROR       = 2'b11
   } mtx_status_t;

   typedef logic [1:0][15:0][4:0] table_t;

   typedef struct packed {
      fsm_t              fsm;
      table_t            dmap;
      table_t            smap;
      table_t            route;
      logic [1:0][4:0]   dcnt;
      logic [1:0][4:0]   scnt;
      logic [1:0][2:0]   lflags;
      level_type_t [1:0] ltype;
      logic [1:0][63:0]  lname;
      mtx_status_t       mstat;
      logic [31:0]       result;
      logic              busy;
      logic              done;
      logic              err;
      logic              scan_src;
      logic [4:0]        idx;
      logic              ack;
      logic [31:0]       prdata;
      logic              slverr;
   } state_t;

endpackage : mm_pkg

// ---- verif/apb_host.sv ----
// apb master model standing in for the host controller
// assumes one clock; the bench calls xfer just after a rising edge
`timescale 1ns/1ns
`default_nettype none
module apb_host (
   input  wire logic        pclk,
   input  wire logic        pready,
   input  wire logic [31:0] prdata,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
   end
   // answer is taken at the rising edge that sees pready high, before that edge's updates land
   // the wait has no count of its own: only the bench timeout ends a hung transfer
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // released lines show a changed pattern, not the last value
      paddr <= ~a;
      pwdata <= ~d;
      @(posedge pclk);
   endtask : xfer
endmodule : apb_host
`default_nettype wire

// ---- verif/matrix_map_config_commands_tb.sv ----
// self-checking bench for the map and configuration command block
// assumes the apb_host model drives the bus; no other stimulus source
`timescale 1ns/1ns
`default_nettype none
module matrix_map_config_commands_tb;
   typedef struct {logic w; logic [7:0] a; logic [31:0] d, m, x; logic e;} row_t;
   localparam logic [31:0] F = 32'hFFFF_FFFF;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   int          n_mismatch, compares, cyc;
   row_t        rows[$];
   matrix_map_config_commands u_matrix_map_config_commands (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr));
   apb_host u_apb_host (.pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
   initial pclk = 1'b0;
   always #2 pclk = ~pclk;
   function automatic row_t wr(logic [7:0] a, logic [31:0] d, logic e);
      return '{1'b1, a, d, '0, '0, e};
   endfunction : wr
   function automatic row_t rr(logic [7:0] a, logic [31:0] m, logic [31:0] x, logic e);
      return '{1'b0, a, '0, m, x, e};
   endfunction : rr
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_apb_host.xfer(w, a, d, rd, er);
   endtask : acc
   // bounded poll: a walk checks at most 17 numbers
   task automatic poll();
      for (int i = 0; i < 40; i++) begin
         acc(1'b0, 8'h04, '0);
         if (rd[0] === 1'b0) break;
      end
      check({31'h0, rd[0]}, '0);
   endtask : poll
   task automatic conclude();
      $display("counts: %0d compares, %0d mismatches", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask : conclude
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_mismatch++;
         conclude();
      end
   end
   initial begin
      cyc = 0;
      presetn = 1'b0;
      rows = '{rr(8'h0C, F, 32'h0001_0300, 1'b0),
         wr(8'h00, 32'h0000_0007, 1'b0), rr(8'h08, F, 32'h8001_0300, 1'b0),
         wr(8'h00, 32'h0000_0302, 1'b0), rr(8'h08, F, 32'h8300_0303, 1'b0),
         wr(8'h00, 32'h0005_0101, 1'b0), rr(8'h04, F, 32'h0000_0002, 1'b0),
         wr(8'h00, 32'h0106_0101, 1'b0), wr(8'h00, 32'h0000_0102, 1'b0),
         rr(8'h08, F, 32'h8100_0506, 1'b0),
         wr(8'h00, 32'h0004_0204, 1'b0), wr(8'h00, 32'h0203_0204, 1'b0),
         wr(8'h00, 32'h0000_0205, 1'b0), rr(8'h08, F, 32'h8200_0304, 1'b0),
         wr(8'h00, 32'h0001_0901, 1'b0), rr(8'h04, 32'h4, 32'h4, 1'b0),
         wr(8'h00, 32'h0302_0101, 1'b0), rr(8'h04, 32'h4, 32'h4, 1'b0),
         wr(8'h00, 32'h0000_0102, 1'b0), rr(8'h08, F, 32'h8100_0506, 1'b0),
         wr(8'h00, 32'h0100_0309, 1'b0), wr(8'h00, 32'h0100_030A, 1'b0),
         rr(8'h08, F, 32'h8000_0000, 1'b0), wr(8'h00, 32'h0200_020A, 1'b0),
         rr(8'h08, F, 32'h8000_0002, 1'b0),
         wr(8'h00, 32'h0000_0309, 1'b0), rr(8'h04, 32'h4, 32'h4, 1'b0),
         wr(8'h00, 32'h0000_000F, 1'b0), rr(8'h04, 32'h4, 32'h4, 1'b0),
         wr(8'h00, 32'h0000_0008, 1'b0), rr(8'h08, F, 32'h8000_0002, 1'b0),
         rr(8'h14, F, 32'h0003_0808, 1'b0),
         wr(8'h10, 32'h0000_0002, 1'b0), rr(8'h04, 32'h30, 32'h20, 1'b0),
         rr(8'h10, F, 32'h0000_0002, 1'b0),
         wr(8'h00, 32'h0000_0818, 1'b0), rr(8'h04, 32'h4, 32'h4, 1'b0),
         wr(8'h24, 32'h4546_4748, 1'b0), rr(8'h24, F, 32'h4546_4748, 1'b0),
         wr(8'h20, 32'h4142_4344, 1'b0), rr(8'h20, F, 32'h4142_4344, 1'b0),
         wr(8'h18, 32'h0067_0804, 1'b0), rr(8'h18, F, 32'h0067_0804, 1'b0),
         wr(8'h14, 32'h0071_1104, 1'b0), rr(8'h14, F, 32'h0001_0804, 1'b0),
         rr(8'h30, F, '0, 1'b1), wr(8'h30, 32'h1, 1'b1)};
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      foreach (rows[i]) begin
         acc(rows[i].w, rows[i].a, rows[i].d);
         check({31'h0, er}, {31'h0, rows[i].e});
         if (rows[i].w == 1'b0) check(rd & rows[i].m, rows[i].x);
      end
      $display("table rows done");
      for (int s = 0; s < 8; s++) begin
         acc(1'b1, 8'h00, 32'h0000_0018 | (s << 8));
         acc(1'b0, 8'h08, '0);
         check(rd & 32'h2007_0300, 32'h2000_0200 | (s << 16));
      end
      $display("descriptive selector test done");
      acc(1'b1, 8'h00, 32'h0000_0203);
      acc(1'b1, 8'h00, 32'h0000_0007);
      check({31'h0, er}, 32'h1);
      poll();
      acc(1'b0, 8'h08, '0);
      check(rd & 32'hC000_0000, 32'h4000_0000);
      acc(1'b1, 8'h00, 32'h0000_0103);
      poll();
      acc(1'b0, 8'h08, '0);
      check(rd, 32'h8100_0506);
      acc(1'b1, 8'h00, 32'h0000_0106);
      poll();
      acc(1'b0, 8'h08, '0);
      check(rd, 32'h8200_0304);
      $display("walk test done");
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      acc(1'b1, 8'h00, 32'h0000_0102);
      acc(1'b0, 8'h08, '0);
      check(rd, 32'h8100_0101);
      $display("reset test done");
      conclude();
   end
endmodule : matrix_map_config_commands_tb
`default_nettype wire
